// ### design/ulpi_func_ctrl_pkg.sv
// constants and types for the ulpi function control register block
// assumes one 8-bit register reached over ulpi register commands
`default_nettype none
package ulpi_func_ctrl_pkg;

  // register layout, bit 7 first in the struct order below
  typedef struct packed {
    logic       reserved;
    logic       phy_low_power_n;
    logic       core_reset;
    logic [1:0] tx_encoding_sel;
    logic       termination_sel;
    logic [1:0] transceiver_speed_sel;
  } func_ctrl_t;

  // register addresses: read at any, write / set / clear at one each
  localparam logic [5:0] FUNC_CTRL_WR_ADDR = 6'h04;
  localparam logic [5:0] FUNC_CTRL_SET_ADDR = 6'h05;
  localparam logic [5:0] FUNC_CTRL_CLR_ADDR = 6'h06;
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h41;

  // bit positions
  localparam int LOW_POWER_N_BIT = 6;
  localparam int CORE_RESET_BIT = 5;

  // encodings
  localparam logic [1:0] ENC_NORMAL = 2'h0;
  localparam logic [1:0] ENC_NON_DRIVING = 2'h1;
  localparam logic [1:0] ENC_NO_STUFF_NRZI = 2'h2;
  localparam logic [1:0] ENC_NO_SYNC_EOP = 2'h3;
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_LS = 2'h2;
  localparam logic [1:0] SPEED_LS_ON_FS = 2'h3;

  // ulpi transmit command byte type field
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;

  // digital core reset length
  localparam int CLK_MHZ = 250;
  localparam int CORE_RST_TIME_NS = 100;
  localparam int CORE_RST_CYCLES_I = (CORE_RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CORE_RST_CYCLES = 8'(CORE_RST_CYCLES_I);

  typedef enum logic [3:0] {
    L_IDLE = 4'h0,
    L_WCMD = 4'h1,
    L_WDATA = 4'h2,
    L_WSTP = 4'h3,
    L_RCMD = 4'h4,
    L_TURN = 4'h5,
    L_DATA = 4'h6,
    L_RST = 4'h7,
    L_RST_GAP = 4'h8,
    L_LP_TURN = 4'h9,
    L_LP = 4'hA
  } link_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_RESET = 2'h1,
    C_WAIT = 2'h2
  } core_st_t;

endpackage
`default_nettype wire

// ### design/ulpi_phy_function_control.sv
// function control register of a ulpi transceiver, with its core-side decode
// assumes ulpi_clk is the interface clock, clk the digital core clock;
// the link drives 00h on the data bus when idle
// line_state and both pull-down enables are clk-domain levels; the
// termination equations are a reduced form of the full resistor table
`default_nettype none
module ulpi_phy_function_control
  import ulpi_func_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ulpi_clk,
  input wire logic [7:0] ulpi_data_in,
  input wire logic ulpi_stp,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic [1:0] line_state,
  input wire logic dplus_pulldown_en,
  input wire logic dminus_pulldown_en,
  output logic core_reset,
  output logic analog_power_en,
  output logic tx_drive_en,
  output logic bit_stuff_nrzi_en,
  output logic auto_sync_eop_en,
  output logic fs_preamble_en,
  output logic [1:0] transceiver_speed_sel,
  output logic [1:0] tx_encoding_sel,
  output logic termination_sel,
  output logic fs_pullup_en,
  output logic hs_term_en
);

  // link-side state, all on ulpi_clk
  link_st_t lst_r;
  link_st_t lst_nxt;
  func_ctrl_t fc_r;
  func_ctrl_t fc_nxt;
  logic [5:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] resp_r;
  logic [1:0] ls_a_r;
  logic [1:0] ls_b_r;
  logic dt_a_r;
  logic dt_b_r;
  logic dt_c_r;

  // core-side state, all on clk; cs_a_r and cs_m_r form the synchroniser,
  // cs_s_r is the sample before and cs_b_r the word the core acts on
  func_ctrl_t cs_a_r;
  func_ctrl_t cs_m_r;
  func_ctrl_t cs_s_r;
  func_ctrl_t cs_b_r;
  core_st_t cst_r;
  logic [7:0] rst_cnt_r;
  logic done_tog_r;

  // command decode of the byte the link is driving
  wire logic [1:0] cmd_type = ulpi_data_in[7:6];
  wire logic is_wr_cmd = (cmd_type == CMD_REG_WRITE) && !ulpi_stp;
  wire logic is_rd_cmd = (cmd_type == CMD_REG_READ) && !ulpi_stp;
  wire logic [7:0] fc_bits = fc_r;
  wire logic rd_hit = (addr_r == FUNC_CTRL_WR_ADDR) || (addr_r == FUNC_CTRL_SET_ADDR) ||
                      (addr_r == FUNC_CTRL_CLR_ADDR);
  wire logic [7:0] rd_value = rd_hit ? fc_bits : 8'h00;
  wire logic [7:0] rxcmd = {6'h00, ls_b_r};
  wire logic done_pulse = dt_b_r ^ dt_c_r;

  // write, set and clear forms; other addresses leave the register alone
  wire logic apply_wr = (lst_r == L_WSTP) && ulpi_stp;
  wire logic [7:0] wr_value =
    (addr_r == FUNC_CTRL_WR_ADDR) ? wdata_r :
    (addr_r == FUNC_CTRL_SET_ADDR) ? (fc_bits | wdata_r) :
    (addr_r == FUNC_CTRL_CLR_ADDR) ? (fc_bits & ~wdata_r) :
    fc_bits;
  wire logic [7:0] after_wr = apply_wr ? wr_value : fc_bits;
  // hardware self-clear / self-set; never coincides with a write state
  wire logic hw_rst_clr = (lst_r == L_RST) && done_pulse;
  wire logic hw_lp_set = (lst_r == L_LP) && ulpi_stp;
  wire logic [7:0] clr_mask = hw_rst_clr ? (8'h01 << CORE_RESET_BIT) : 8'h00;
  wire logic [7:0] set_mask = hw_lp_set ? (8'h01 << LOW_POWER_N_BIT) : 8'h00;
  assign fc_nxt = (after_wr & ~clr_mask) | set_mask;

  // bus sequences as seen from the link, one ulpi_clk cycle per step:
  //   write: cmd taken in idle, nxt for two cycles, data byte taken in the
  //          second, register updated at the edge that sees stp
  //   read:  cmd taken in idle, nxt for one cycle, dir up for a turnaround
  //          cycle, one data cycle with oe high, then dir drops
  //   stp while the write cmd is still being acked aborts the write
  // commands are only decoded in idle, so one driven while dir is high
  // (reset pending or low power) is ignored rather than queued
  // link state sequencing; reset request outranks suspend, both outrank commands
  always_comb begin
    lst_nxt = lst_r;
    case (lst_r)
      L_IDLE: begin
        if (fc_r.core_reset) begin
          lst_nxt = L_RST;
        end else if (!fc_r.phy_low_power_n) begin
          lst_nxt = L_LP_TURN;
        end else if (is_wr_cmd) begin
          lst_nxt = L_WCMD;
        end else if (is_rd_cmd) begin
          lst_nxt = L_RCMD;
        end
      end
      L_WCMD: lst_nxt = ulpi_stp ? L_IDLE : L_WDATA;
      L_WDATA: lst_nxt = L_WSTP;
      L_WSTP: lst_nxt = ulpi_stp ? L_IDLE : L_WSTP;
      L_RCMD: lst_nxt = L_TURN;
      L_TURN: lst_nxt = L_DATA;
      L_DATA: lst_nxt = L_IDLE;
      L_RST: lst_nxt = done_pulse ? L_RST_GAP : L_RST;
      L_RST_GAP: lst_nxt = L_TURN;
      L_LP_TURN: lst_nxt = L_LP;
      L_LP: lst_nxt = ulpi_stp ? L_IDLE : L_LP;
      default: lst_nxt = L_IDLE;
    endcase
  end

  // register and state; the core reset never touches these
  // bits 5 and 6 are moved by hardware only in states that apply no write
  always_ff @(posedge ulpi_clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_r <= L_IDLE;
      fc_r <= FUNC_CTRL_RESET;
    end else begin
      lst_r <= lst_nxt;
      fc_r <= fc_nxt;
    end
  end

  // address and data capture during a register command
  // (addr_r serves reads too; wdata_r is only used at the stp edge)
  always_ff @(posedge ulpi_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 6'h00;
      wdata_r <= 8'h00;
      resp_r <= 8'h00;
    end else begin
      if (lst_r == L_IDLE && (is_wr_cmd || is_rd_cmd)) addr_r <= ulpi_data_in[5:0];
      if (lst_r == L_WDATA) wdata_r <= ulpi_data_in;
      if (lst_r == L_RCMD) resp_r <= rd_value;
      if (lst_r == L_RST_GAP) resp_r <= rxcmd;
    end
  end

  // ulpi pins; dir rises a cycle before data is driven to avoid contention
  // pins are decoded from lst_nxt so every pin is a flop moving with the state
  // data_out returns to 00h whenever oe is low, so no stale byte shows
  always_ff @(posedge ulpi_clk or negedge rst_n) begin
    if (!rst_n) begin
      ulpi_dir <= 1'b0;
      ulpi_nxt <= 1'b0;
      ulpi_data_oe <= 1'b0;
      ulpi_data_out <= 8'h00;
    end else begin
      ulpi_nxt <= (lst_nxt == L_WCMD) || (lst_nxt == L_WDATA) || (lst_nxt == L_RCMD);
      ulpi_dir <= (lst_nxt == L_TURN) || (lst_nxt == L_DATA) || (lst_nxt == L_RST) ||
                  (lst_nxt == L_LP_TURN) || (lst_nxt == L_LP);
      ulpi_data_oe <= (lst_nxt == L_DATA) || (lst_nxt == L_LP);
      if (lst_nxt == L_DATA) begin
        ulpi_data_out <= resp_r;
      end else if (lst_nxt == L_LP) begin
        ulpi_data_out <= rxcmd; // line state shown while suspended
      end else begin
        ulpi_data_out <= 8'h00;
      end
    end
  end

  // line state and reset-done toggle into the ulpi domain
  // the done event crosses as a toggle, so its clk-side length does not matter
  always_ff @(posedge ulpi_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_a_r <= 2'h0;
      ls_b_r <= 2'h0;
      dt_a_r <= 1'b0;
      dt_b_r <= 1'b0;
      dt_c_r <= 1'b0;
    end else begin
      ls_a_r <= line_state;
      ls_b_r <= ls_a_r;
      dt_a_r <= done_tog_r;
      dt_b_r <= dt_a_r;
      dt_c_r <= dt_b_r;
    end
  end

  // register word into the core domain: a two-flop sync per bit, then the
  // word is only taken once two synced samples in a row agree, so a mixed
  // word caught mid-change (one bit old, one new) never reaches the decode;
  // this holds because the register moves at most once per ulpi_clk period,
  // which spans more than two clk periods; the cost is two more clk of lag
  wire logic cs_same = (cs_m_r == cs_s_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_a_r <= FUNC_CTRL_RESET;
      cs_m_r <= FUNC_CTRL_RESET;
      cs_s_r <= FUNC_CTRL_RESET;
      cs_b_r <= FUNC_CTRL_RESET;
    end else begin
      cs_a_r <= fc_r;
      cs_m_r <= cs_a_r;
      cs_s_r <= cs_m_r;
      if (cs_same) cs_b_r <= cs_s_r;
    end
  end

  // core reset pulse of fixed length, rearmed only once the bit has cleared
  // the wait state stops a second pulse while the bit still reads as set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_r <= C_IDLE;
      rst_cnt_r <= 8'h00;
      core_reset <= 1'b0;
      done_tog_r <= 1'b0;
    end else begin
      case (cst_r)
        C_IDLE: begin
          if (cs_b_r.core_reset) begin
            cst_r <= C_RESET;
            rst_cnt_r <= 8'h00;
            core_reset <= 1'b1;
          end
        end
        C_RESET: begin
          rst_cnt_r <= rst_cnt_r + 8'h01;
          if (rst_cnt_r == CORE_RST_CYCLES - 8'h01) begin
            cst_r <= C_WAIT;
            core_reset <= 1'b0;
            done_tog_r <= ~done_tog_r;
          end
        end
        C_WAIT: begin
          if (!cs_b_r.core_reset) cst_r <= C_IDLE;
        end
        default: cst_r <= C_IDLE;
      endcase
    end
  end

  // decoded controls for the analog and serial engine
  // each output below is a flop, so no decode glitch reaches the analog side
  wire logic [1:0] enc = cs_b_r.tx_encoding_sel;
  wire logic [1:0] spd = cs_b_r.transceiver_speed_sel;
  wire logic any_pd = dplus_pulldown_en || dminus_pulldown_en;
  // pull-up only as a peripheral (no pulldowns), never in non-driving mode
  wire logic pullup_d = cs_b_r.termination_sel && (spd != SPEED_HS) &&
                        (enc != ENC_NON_DRIVING) && !any_pd;
  wire logic hs_term_d = !cs_b_r.termination_sel && (spd == SPEED_HS) &&
                         (enc != ENC_NON_DRIVING);

  // outputs to the analog and serial engine, one clk after the decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_power_en <= 1'b1;
      tx_drive_en <= 1'b1;
      bit_stuff_nrzi_en <= 1'b1;
      auto_sync_eop_en <= 1'b1;
      fs_preamble_en <= 1'b0;
      transceiver_speed_sel <= SPEED_FS;
      tx_encoding_sel <= ENC_NORMAL;
      termination_sel <= 1'b0;
      fs_pullup_en <= 1'b0;
      hs_term_en <= 1'b0;
    end else begin
      // receiver, comparators and pins stay on regardless of this enable
      analog_power_en <= cs_b_r.phy_low_power_n;
      tx_drive_en <= (enc != ENC_NON_DRIVING);
      bit_stuff_nrzi_en <= (enc != ENC_NO_STUFF_NRZI);
      auto_sync_eop_en <= (enc != ENC_NO_SYNC_EOP);
      fs_preamble_en <= (spd == SPEED_LS_ON_FS);
      transceiver_speed_sel <= spd;
      tx_encoding_sel <= enc;
      termination_sel <= cs_b_r.termination_sel;
      fs_pullup_en <= pullup_d && cs_b_r.phy_low_power_n;
      hs_term_en <= hs_term_d && cs_b_r.phy_low_power_n;
    end
  end

endmodule
`default_nettype wire

// ### sim/ulpi_func_ctrl_monitor.sv
// assertions on the function control block ports
// assumes dir and oe move only on ulpi_clk edges, never at a clk edge
`default_nettype none
module ulpi_func_ctrl_monitor
  import ulpi_func_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ulpi_data_oe,
  input wire logic ulpi_dir,
  input wire logic core_reset,
  input wire logic analog_power_en,
  input wire logic tx_drive_en,
  input wire logic bit_stuff_nrzi_en,
  input wire logic fs_preamble_en,
  input wire logic [1:0] transceiver_speed_sel,
  input wire logic [1:0] tx_encoding_sel,
  input wire logic termination_sel,
  input wire logic fs_pullup_en,
  input wire logic hs_term_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // all in clk: sampling dir and oe here is safe as both change only on ulpi_clk edges
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_nodrive_enc: assert property (tx_drive_en == (tx_encoding_sel != ENC_NON_DRIVING))
    else $error("tx drive wrong");
  a_nostuff_enc: assert property (bit_stuff_nrzi_en == (tx_encoding_sel != 2'h2))
    else $error("stuffing wrong");
  a_preamble_speed: assert property (fs_preamble_en == (transceiver_speed_sel == 2'h3))
    else $error("preamble wrong");
  a_hs_term: assert property (hs_term_en |->
    !termination_sel && transceiver_speed_sel == 2'h0) else $error("hs term wrong");
  a_power_off: assert property (!analog_power_en |-> !fs_pullup_en && !hs_term_en)
    else $error("term in low power");
  // pulse length is a fixed 25 clk cycles
  a_core_len: assert property ($fell(core_reset) |->
    $past(core_reset, 25) && !$past(core_reset, 26)) else $error("reset length wrong");
  a_reset_dir: assert property ($fell(core_reset) |-> ulpi_dir)
    else $error("dir low in reset");
  a_oe_dir: assert property (ulpi_data_oe |-> ulpi_dir)
    else $error("oe without dir");
  c_reset: cover property ($rose(core_reset));
  c_low_power: cover property ($fell(analog_power_en));
  c_read: cover property ($rose(ulpi_data_oe));
endmodule

bind ulpi_phy_function_control ulpi_func_ctrl_monitor ulpi_func_ctrl_monitor_i (.clk, .rst_n,
  .ulpi_data_oe, .ulpi_dir, .core_reset, .analog_power_en, .tx_drive_en, .bit_stuff_nrzi_en,
  .fs_preamble_en, .transceiver_speed_sel, .tx_encoding_sel, .termination_sel,
  .fs_pullup_en, .hs_term_en);
`default_nettype wire

// ### sim/ulpi_link_model.sv
// link controller model: register write, read and stp wake-up
// assumes device outputs change on rising ulpi_clk; hangs end the run in tb
`default_nettype none
module ulpi_link_model (
  input wire logic ulpi_clk,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic ulpi_data_oe,
  input wire logic [7:0] ulpi_data_out,
  output logic ulpi_stp,
  output logic [7:0] ulpi_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drv_r = 8'h00;
  // a released bus shows the inverse of the last byte, never a clean level
  assign ulpi_data_in = ulpi_dir ? ~drv_r : drv_r;
  initial ulpi_stp = 1'b0;
  // bounded wait for a level on dir (0), nxt (1) or oe (2) seen at an edge
  task automatic wait_on(input int sel, input logic lvl);
    logic [2:0] s;
    int n;
    n = 0;
    do begin
      @(posedge ulpi_clk);
      s = {ulpi_data_oe, ulpi_nxt, ulpi_dir};
      n++;
    end while (s[sel] !== lvl && n < 60);
    if (s[sel] !== lvl) tb.hang();
  endtask
  // no packets are ever sent, so any encoding stays legal
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ulpi_clk);
    #1 drv_r = {2'b10, a};
    wait_on(1, 1'b1);
    #1 drv_r = d;
    @(posedge ulpi_clk);
    #1 drv_r = 8'h00;
    ulpi_stp = 1'b1;
    @(posedge ulpi_clk);
    #1 ulpi_stp = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge ulpi_clk);
    #1 drv_r = {2'b11, a};
    wait_on(1, 1'b1);
    #1 drv_r = 8'h00;
    wait_on(2, 1'b1);
    q = ulpi_data_out;
    wait_on(0, 1'b0);
  endtask
  // write cut short: stp in the first nxt cycle, so no data byte is taken
  task automatic wr_abort(input logic [5:0] a);
    @(posedge ulpi_clk);
    #1 drv_r = {2'b10, a};
    @(posedge ulpi_clk);
    #1 drv_r = 8'h00;
    ulpi_stp = 1'b1;
    @(posedge ulpi_clk);
    #1 ulpi_stp = 1'b0;
  endtask
  // stp is the only way out of low power
  task automatic wake();
    wait_on(2, 1'b1);
    #1 ulpi_stp = 1'b1;
    @(posedge ulpi_clk);
    #1 ulpi_stp = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// bench for the function control register block with a link model
// assumes the link model owns the ulpi side; bench drives core-side inputs
`default_nettype none
module tb;
  import ulpi_func_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, ulpi_clk, rst_n, stp, dir, nxt, oe, cr, ape, tde, bsn, ase, fpe, ts, fpu, hst;
  logic dpd, dmd;
  logic [1:0] ls, spd, enc;
  logic [5:0] a;
  logic [7:0] din, dout, q, d, exp_r;
  int num_errors, n_compared, seed, i, len;
  wire [1:0] e_enc = exp_r[4:3];
  wire [1:0] e_spd = exp_r[1:0];
  // controls expected from the stored fields, in port order of the seen vector
  wire [7:0] e_dec = {1'b1, e_enc != 2'h1, e_enc != 2'h2, e_enc != 2'h3, e_spd == 2'h3,
    exp_r[2] && e_spd != 2'h0 && e_enc != 2'h1 && !dpd && !dmd,
    !exp_r[2] && e_spd == 2'h0 && e_enc != 2'h1, 1'b0};
  ulpi_phy_function_control ulpi_phy_function_control_i (.clk(clk), .rst_n(rst_n),
    .ulpi_clk(ulpi_clk), .ulpi_data_in(din), .ulpi_stp(stp), .ulpi_data_out(dout),
    .ulpi_data_oe(oe), .ulpi_dir(dir), .ulpi_nxt(nxt), .line_state(ls),
    .dplus_pulldown_en(dpd), .dminus_pulldown_en(dmd), .core_reset(cr),
    .analog_power_en(ape), .tx_drive_en(tde), .bit_stuff_nrzi_en(bsn),
    .auto_sync_eop_en(ase), .fs_preamble_en(fpe), .transceiver_speed_sel(spd),
    .tx_encoding_sel(enc), .termination_sel(ts), .fs_pullup_en(fpu), .hs_term_en(hst));
  ulpi_link_model ulpi_link_model_i (.ulpi_clk(ulpi_clk), .ulpi_dir(dir), .ulpi_nxt(nxt),
    .ulpi_data_oe(oe), .ulpi_data_out(dout), .ulpi_stp(stp), .ulpi_data_in(din));
  // clocks: ulpi_clk offset so its edges never meet clk edges
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    ulpi_clk = 1'b0;
    #3.3;
    forever #7.5 ulpi_clk = ~ulpi_clk;
  end
  // core reset pulse length in clk cycles
  always @(posedge clk) if (cr === 1'b1) len <= len + 1;
  function automatic logic [7:0] upd(input logic [7:0] c, input logic [5:0] a,
    input logic [7:0] v);
    case (a)
      6'h04: return v;
      6'h05: return c | v;
      6'h06: return c & ~v;
      default: return c;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    $display("unexpected wait expected level seen timeout");
    final_report();
  endtask
  initial begin
    seed = 65;
    rst_n = 1'b0;
    {ls, dpd, dmd} = 4'h0;
    // counted in ulpi_clk so both domains see at least two edges
    repeat (6) @(posedge ulpi_clk);
    #1 rst_n = 1'b1;
    exp_r = 8'h41;
    for (i = 4; i < 7; i++) begin
      ulpi_link_model_i.rd(6'(i), q);
      chk("reset value", exp_r, q);
    end
    $display("test reset values done");
    // random write, set, clear and unmapped 07h; bits 5 and 6 kept idle
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 {ls, dpd, dmd} = 4'($random(seed));
      a = 6'h04 + 6'($random(seed) & 3);
      d = 8'($random(seed));
      d = (a == 6'h06) ? (d & 8'hBF) : ((d | 8'h40) & 8'hDF);
      ulpi_link_model_i.wr(a, d);
      exp_r = upd(exp_r, a, d);
      a = 6'h04 + 6'($random(seed) & 3);
      ulpi_link_model_i.rd(a, q);
      chk("register", (a == 6'h07) ? 8'h00 : exp_r, q);
      chk("fields", {3'h0, exp_r[4:0]}, {3'h0, enc, ts, spd});
      chk("decode", e_dec, {ape, tde, bsn, ase, fpe, fpu, hst, 1'b0});
    end
    // a write cut short by stp leaves the register as it was
    ulpi_link_model_i.wr_abort(6'h04);
    ulpi_link_model_i.rd(6'h05, q);
    chk("aborted write", exp_r, q);
    $display("test random access done");
    // low power until stp, then the bit is back without a write
    ulpi_link_model_i.wr(6'h06, 8'h40);
    ulpi_link_model_i.wait_on(2, 1'b1);
    chk("low power rxcmd", {6'h00, ls}, dout);
    chk("low power", 8'h00, {7'h0, ape});
    ulpi_link_model_i.wake();
    ulpi_link_model_i.rd(6'h04, q);
    chk("after wake", exp_r, q);
    $display("test low power done");
    // core reset: bus left alone until dir falls, then rxcmd
    ulpi_link_model_i.wr(6'h05, 8'h20);
    ulpi_link_model_i.wait_on(0, 1'b1);
    ulpi_link_model_i.wait_on(0, 1'b0);
    ulpi_link_model_i.wait_on(2, 1'b1);
    chk("reset rxcmd", {6'h00, ls}, dout);
    ulpi_link_model_i.wait_on(0, 1'b0);
    chk("pulse length", CORE_RST_CYCLES, 8'(len));
    ulpi_link_model_i.rd(6'h06, q);
    chk("after reset", exp_r, q);
    $display("test core reset done");
    final_report();
  end
endmodule
`default_nettype wire
